// ---- ardc_pkg.sv ----
// Purpose: Shared constants for the accelerometer rate, ready and direction block.
// Assumes: 50 MHz system clock; 8-bit register addresses and data.
// Notes:   Register map, field positions, reset values and timing counts.
`default_nettype none

package ardc_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned MOD_RATE_HZ  = 20480;      // Decimator input rate.
  localparam int unsigned EXT_CLK_HZ   = 1_045_000;
  localparam int unsigned MOD_DIV      = CLK_HZ / MOD_RATE_HZ;
  localparam int unsigned EXT_DIV      = EXT_CLK_HZ / MOD_RATE_HZ;
  localparam int unsigned MIN_DECIM    = 8;
  localparam int unsigned NEW_DATA_US  = 150;
  localparam int unsigned READ_WIN_CYC =
    MOD_DIV * MIN_DECIM - NEW_DATA_US * (CLK_HZ / 1_000_000);
  localparam logic [3:0]  HP_SHIFT_BASE = 4'h9;     // Cut-off code 0 is 512.

  // ==========================================================================
  // Register addresses
  localparam logic [7:0] ADDR_CTRL1    = 8'h20;
  localparam logic [7:0] ADDR_CTRL2    = 8'h21;
  localparam logic [7:0] ADDR_CTRL3    = 8'h22;
  localparam logic [7:0] ADDR_FILT_REF = 8'h23;
  localparam logic [7:0] ADDR_STATUS   = 8'h27;
  localparam logic [7:0] ADDR_OUT_X_L  = 8'h28;
  localparam logic [7:0] ADDR_OUT_Z_H  = 8'h2D;
  localparam logic [7:0] ADDR_DIR_CFG  = 8'h38;
  localparam logic [7:0] ADDR_DIR_SRC  = 8'h39;
  localparam logic [7:0] ADDR_DIR_ACK  = 8'h3A;
  localparam logic [7:0] ADDR_IN_L     = 8'h3C;
  localparam logic [7:0] ADDR_IN_H     = 8'h3D;
  localparam logic [7:0] ADDR_OUT_L    = 8'h3E;
  localparam logic [7:0] ADDR_OUT_H    = 8'h3F;

  // ==========================================================================
  // Field positions
  localparam int unsigned CTRL1_PWR_HI  = 7;
  localparam int unsigned CTRL1_PWR_LO  = 6;
  localparam int unsigned CTRL1_DECIM_HI = 5;
  localparam int unsigned CTRL1_DECIM_LO = 4;
  localparam int unsigned CTRL2_IEN     = 3;
  localparam int unsigned CTRL2_READY_OUTPUT_ENABLE    = 2;
  localparam int unsigned CTRL3_ECK     = 7;
  localparam int unsigned CTRL3_HPDD    = 6;
  localparam int unsigned STATUS_OVR    = 7;
  localparam int unsigned STATUS_DA     = 3;
  localparam int unsigned DIRCFG_EN     = 7;
  localparam int unsigned DIRCFG_LATCH  = 6;
  localparam int unsigned DIRSRC_IA     = 6;

  // ==========================================================================
  // Reset values and the example set-up
  localparam logic [7:0] CTRL1_RST     = 8'h07;
  localparam logic [7:0] CTRL2_RST     = 8'h00;
  localparam logic [7:0] CTRL3_RST     = 8'h08;
  localparam logic [7:0] EX_CTRL1      = 8'hC7;
  localparam logic [7:0] EX_CTRL2_INT  = 8'h08;
  localparam logic [7:0] EX_CTRL2_RDY  = 8'h04;
  localparam logic [7:0] EX_CTRL3      = 8'h4B;
  localparam logic [7:0] EX_OUTER_L    = 8'hA3;
  localparam logic [7:0] EX_OUTER_H    = 8'h10;
  localparam logic [7:0] EX_INNER_L    = 8'h99;
  localparam logic [7:0] EX_INNER_H    = 8'h09;
  localparam logic [7:0] EX_DIR_CFG    = 8'hCF;

  // Log2 of the decimation factor: 512, 128, 32, 8.
  function automatic logic [3:0] decim_log2(input logic [1:0] df);
    case (df)
      2'h0:    return 4'h9;
      2'h1:    return 4'h7;
      2'h2:    return 4'h5;
      default: return 4'h3;
    endcase
  endfunction : decim_log2

endpackage : ardc_pkg

`default_nettype wire

// ---- ardc_if.sv ----
// Purpose: Register port and shared ready/interrupt pin between host and sensor.
// Assumes: Both ends run on the same system clock.
// Notes:   Read data stand in the cycle after the read strobe only.
`timescale 1ns/1ps
`default_nettype none

interface ardc_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       rdy_int;

  modport dev (
    input  addr,
    input  wdata,
    input  wr,
    input  rd,
    output rdata,
    output rdy_int
  );

  modport hst (
    output addr,
    output wdata,
    output wr,
    output rd,
    input  rdata,
    input  rdy_int
  );
endinterface : ardc_if

`default_nettype wire

// ---- ardc_device.sv ----
// Purpose: Sensor-side rate, data-ready and direction-detection logic.
// Assumes: Acceleration words arrive synchronous to sys_clk_i.
// Notes:   The ready/interrupt pin is decoded from flops only.
// Functional notes
// - Flag orientation changes on the shared pin.
// - Outer threshold kept as low and high byte.
// - Inner threshold kept as low and high byte.
// - Filter-reset read loads reference immediately, anytime.
// - Direction config CFh enables X and Y.
// - Control three 4Bh enables filter, cut-off 4096.
// - Direction source read returns tilt direction.
// - Direction acknowledge read clears latched request.
// - Host polls pin, reads source, then acknowledge.
// - Decimation field resets to zero, factor 512.
// - Decimation codes give 512, 128, 32, 8.
// - Host finishes reading before new data slot.
// - Ready falls after full read, rises on new.
// - Status register records overrun on lost samples.
// - Status bit 3 holds data ready.
// - Pin carries ready or interrupt by enables.
// - Interrupt wins when both enables set.
// - Ready clears once all enabled axes read.
// - External clock select drives internal timing.
// - Detected events latched until host acknowledges.
`timescale 1ns/1ps
`default_nettype none

module ardc_device #(
  parameter int unsigned MOD_DIV_P = ardc_pkg::MOD_DIV,
  parameter int unsigned EXT_DIV_P = ardc_pkg::EXT_DIV
) (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // Host side
  ardc_if.dev              bus,
  // Sensor side
  input  wire logic        ext_clk_i,
  input  wire logic [15:0] accel_x_i,
  input  wire logic [15:0] accel_y_i,
  input  wire logic [15:0] accel_z_i
);

  // ==========================================================================
  // Register file
  logic [7:0] control_one;
  logic [7:0] control_two;
  logic [7:0] control_three;
  logic [7:0] direction_config;
  logic [7:0] inner_threshold_low;
  logic [7:0] inner_threshold_high;
  logic [7:0] outer_threshold_low;
  logic [7:0] outer_threshold_high;

  function automatic logic hit(input logic s, input logic [7:0] a, input logic [7:0] r);
    return s && (a == r);
  endfunction : hit

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      control_one          <= ardc_pkg::CTRL1_RST;
      control_two          <= ardc_pkg::CTRL2_RST;
      control_three        <= ardc_pkg::CTRL3_RST;
      direction_config     <= 8'h00;
      inner_threshold_low  <= 8'h00;
      inner_threshold_high <= 8'h00;
      outer_threshold_low  <= 8'h00;
      outer_threshold_high <= 8'h00;
    end else if (bus.wr) begin
      case (bus.addr)
        ardc_pkg::ADDR_CTRL1:   control_one          <= bus.wdata;
        ardc_pkg::ADDR_CTRL2:   control_two          <= bus.wdata;
        ardc_pkg::ADDR_CTRL3:   control_three        <= bus.wdata;
        ardc_pkg::ADDR_DIR_CFG: direction_config     <= bus.wdata;
        ardc_pkg::ADDR_IN_L:    inner_threshold_low  <= bus.wdata;
        ardc_pkg::ADDR_IN_H:    inner_threshold_high <= bus.wdata;
        ardc_pkg::ADDR_OUT_L:   outer_threshold_low  <= bus.wdata;
        ardc_pkg::ADDR_OUT_H:   outer_threshold_high <= bus.wdata;
        default: ;
      endcase
    end
  end

  logic       pwr_on;
  logic       use_ext;
  logic       hp_on;
  logic [2:0] axis_en;
  logic [3:0] hp_shift;
  logic       rd_ref;
  logic       rd_ack;

  assign pwr_on   = control_one[ardc_pkg::CTRL1_PWR_HI] | control_one[ardc_pkg::CTRL1_PWR_LO];
  assign use_ext  = control_three[ardc_pkg::CTRL3_ECK];
  assign hp_on    = control_three[ardc_pkg::CTRL3_HPDD];
  assign axis_en  = control_one[2:0];
  assign hp_shift = ardc_pkg::HP_SHIFT_BASE + {2'b00, control_three[1:0]};
  assign rd_ref   = hit(bus.rd, bus.addr, ardc_pkg::ADDR_FILT_REF);
  assign rd_ack   = hit(bus.rd, bus.addr, ardc_pkg::ADDR_DIR_ACK);

  // ==========================================================================
  // Sample timing
  // The external clock is a pin, so it is synchronised before its edge is used.
  logic [2:0]  ext_sync;
  logic        ext_rise;
  logic        mod_step;
  logic [11:0] mod_cnt;
  logic [11:0] mod_lim;
  logic        mod_tick;
  logic [8:0]  dec_cnt;
  logic [8:0]  dec_max;
  logic        sample_tick;
  logic        sample_q;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_sync <= 3'h0;
    end else begin
      ext_sync <= {ext_sync[1:0], ext_clk_i};
    end
  end

  assign ext_rise = ext_sync[1] & ~ext_sync[2];
  assign mod_step = use_ext ? ext_rise : 1'b1;
  assign mod_lim  = use_ext ? 12'(EXT_DIV_P - 1) : 12'(MOD_DIV_P - 1);
  assign mod_tick = pwr_on & mod_step & (mod_cnt >= mod_lim);
  assign dec_max  = 9'((10'h001 << ardc_pkg::decim_log2(
                    control_one[ardc_pkg::CTRL1_DECIM_HI:ardc_pkg::CTRL1_DECIM_LO]))
                    - 10'h001);
  assign sample_tick = mod_tick & (dec_cnt >= dec_max);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mod_cnt <= 12'h000;
    end else if (!pwr_on || mod_tick) begin
      mod_cnt <= 12'h000;
    end else if (mod_step) begin
      mod_cnt <= mod_cnt + 12'h001;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dec_cnt <= 9'h000;
    end else if (!pwr_on || sample_tick) begin
      dec_cnt <= 9'h000;
    end else if (mod_tick) begin
      dec_cnt <= dec_cnt + 9'h001;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sample_q <= 1'b0;
    end else begin
      sample_q <= sample_tick;
    end
  end

  // ==========================================================================
  // Per-axis sample, reference and direction
  logic signed [15:0] acc_in   [3];
  logic        [15:0] out_data [3];
  logic        [1:0]  dir_st   [3];
  logic        [2:0]  rd_hi;
  logic signed [17:0] outer_s;
  logic signed [17:0] inner_s;

  assign acc_in[0] = accel_x_i;
  assign acc_in[1] = accel_y_i;
  assign acc_in[2] = accel_z_i;
  assign outer_s   = {2'b00, outer_threshold_high, outer_threshold_low};
  assign inner_s   = {2'b00, inner_threshold_high, inner_threshold_low};

  for (genvar k = 0; k < 3; k++) begin : g_axis
    logic signed [15:0] ref_q;
    logic signed [16:0] diff;
    logic signed [16:0] step;
    logic signed [17:0] v;

    assign diff = {acc_in[k][15], acc_in[k]} - {ref_q[15], ref_q};
    assign step = diff >>> hp_shift;
    assign v    = hp_on ? {diff[16], diff} : {{2{acc_in[k][15]}}, acc_in[k]};
    assign rd_hi[k] = hit(bus.rd, bus.addr, ardc_pkg::ADDR_OUT_X_L + 8'((2 * k) + 1));

    // The reference snaps on a filter-reset read instead of settling slowly.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        ref_q <= 16'h0000;
      end else if (rd_ref) begin
        ref_q <= acc_in[k];
      end else if (sample_tick && hp_on) begin
        ref_q <= ref_q + step[15:0];
      end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        out_data[k] <= 16'h0000;
      end else if (sample_tick) begin
        out_data[k] <= acc_in[k];
      end
    end

    // Between the inner and outer bands the last direction is held.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        dir_st[k] <= 2'b00;
      end else if (sample_tick) begin
        if (v > outer_s) begin
          dir_st[k] <= 2'b10;
        end else if (v < -outer_s) begin
          dir_st[k] <= 2'b01;
        end else if ((v < inner_s) && (v > -inner_s)) begin
          dir_st[k] <= 2'b00;
        end
      end
    end
  end

  // ==========================================================================
  // Data ready and overrun
  logic       ready;
  logic       overrun;
  logic [2:0] read_done;
  logic [2:0] next_done;
  logic       all_read;

  assign next_done = read_done | rd_hi;
  assign all_read  = (axis_en != 3'h0) && ((next_done & axis_en) == axis_en);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready     <= 1'b0;
      read_done <= 3'h0;
    end else if (sample_tick) begin
      ready     <= 1'b1;
      read_done <= 3'h0;
    end else if (all_read) begin
      ready     <= 1'b0;
      read_done <= 3'h0;
    end else begin
      read_done <= next_done;
    end
  end

  // A new sample landing on unread data marks an overrun; a full read clears it.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      overrun <= 1'b0;
    end else if (sample_tick && ready && !all_read) begin
      overrun <= 1'b1;
    end else if (ready && all_read) begin
      overrun <= 1'b0;
    end
  end

  // ==========================================================================
  // Direction change detection
  logic [5:0] dir_now;
  logic [5:0] dir_prev;
  logic [5:0] dir_src;
  logic       dir_event;
  logic       irq;

  assign dir_now   = {dir_st[2], dir_st[1], dir_st[0]} & direction_config[5:0];
  assign dir_event = sample_q & direction_config[ardc_pkg::DIRCFG_EN]
                     & (dir_now != dir_prev);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dir_prev <= 6'h00;
      dir_src  <= 6'h00;
    end else if (dir_event) begin
      dir_prev <= dir_now;
      dir_src  <= dir_now;
    end
  end

  // A new event in the acknowledge cycle keeps the request set.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq <= 1'b0;
    end else if (dir_event) begin
      irq <= 1'b1;
    end else if (rd_ack) begin
      irq <= 1'b0;
    end else if (sample_q && !direction_config[ardc_pkg::DIRCFG_LATCH]) begin
      irq <= 1'b0;
    end
  end

  // ==========================================================================
  // Shared pin and read port
  assign bus.rdy_int = control_two[ardc_pkg::CTRL2_IEN] ? irq :
                       (control_two[ardc_pkg::CTRL2_READY_OUTPUT_ENABLE] & ready);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus.rdata <= 8'h00;
    end else if (!bus.rd) begin
      bus.rdata <= 8'h00;
    end else begin
      case (bus.addr)
        ardc_pkg::ADDR_CTRL1:   bus.rdata <= control_one;
        ardc_pkg::ADDR_CTRL2:   bus.rdata <= control_two;
        ardc_pkg::ADDR_CTRL3:   bus.rdata <= control_three;
        ardc_pkg::ADDR_STATUS:  bus.rdata <= {overrun, 3'h0, ready, 3'h0};
        8'h28:                  bus.rdata <= out_data[0][7:0];
        8'h29:                  bus.rdata <= out_data[0][15:8];
        8'h2A:                  bus.rdata <= out_data[1][7:0];
        8'h2B:                  bus.rdata <= out_data[1][15:8];
        8'h2C:                  bus.rdata <= out_data[2][7:0];
        ardc_pkg::ADDR_OUT_Z_H: bus.rdata <= out_data[2][15:8];
        ardc_pkg::ADDR_DIR_CFG: bus.rdata <= direction_config;
        ardc_pkg::ADDR_DIR_SRC: bus.rdata <= {1'b0, irq, dir_src};
        ardc_pkg::ADDR_IN_L:    bus.rdata <= inner_threshold_low;
        ardc_pkg::ADDR_IN_H:    bus.rdata <= inner_threshold_high;
        ardc_pkg::ADDR_OUT_L:   bus.rdata <= outer_threshold_low;
        ardc_pkg::ADDR_OUT_H:   bus.rdata <= outer_threshold_high;
        default:                bus.rdata <= 8'h00;
      endcase
    end
  end

endmodule : ardc_device

`default_nettype wire

// ---- ardc_host.sv ----
// Purpose: Host controller that configures the sensor and services its pin.
// Assumes: Same clock as the sensor; pin needs no synchroniser.
// Notes:   Direction mode or data mode is chosen at start.
`timescale 1ns/1ps
`default_nettype none

module ardc_host #(
  parameter int unsigned READ_WIN_P = ardc_pkg::READ_WIN_CYC
) (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // Sensor side
  ardc_if.hst              bus,
  // User side
  input  wire logic        start_i,
  input  wire logic        mode_data_i,
  input  wire logic        ext_clk_sel_i,
  output logic             busy_o,
  output logic             done_o,
  output logic             late_o,
  output logic [7:0]       dir_src_o,
  output logic [7:0]       status_o,
  output logic [15:0]      accel_x_o,
  output logic [15:0]      accel_y_o,
  output logic [15:0]      accel_z_o
);

  typedef enum logic [3:0] {
    ARDC_H_IDLE = 4'b0001,
    ARDC_H_CFG  = 4'b0010,
    ARDC_H_POLL = 4'b0100,
    ARDC_H_READ = 4'b1000
  } ardc_hstate_t;

  // ==========================================================================
  // Sequences: {read, address, data}
  function automatic logic [16:0] cfg_op(input logic [3:0] i, input logic dm, input logic ek);
    case (i)
      4'h0:    return {1'b0, ardc_pkg::ADDR_CTRL1, ardc_pkg::EX_CTRL1};
      4'h1:    return {1'b0, ardc_pkg::ADDR_CTRL2,
                       dm ? ardc_pkg::EX_CTRL2_RDY : ardc_pkg::EX_CTRL2_INT};
      4'h2:    return {1'b0, ardc_pkg::ADDR_CTRL3, ardc_pkg::EX_CTRL3 | {ek, 7'h00}};
      4'h3:    return {1'b0, ardc_pkg::ADDR_OUT_L, ardc_pkg::EX_OUTER_L};
      4'h4:    return {1'b0, ardc_pkg::ADDR_OUT_H, ardc_pkg::EX_OUTER_H};
      4'h5:    return {1'b0, ardc_pkg::ADDR_IN_L, ardc_pkg::EX_INNER_L};
      4'h6:    return {1'b0, ardc_pkg::ADDR_IN_H, ardc_pkg::EX_INNER_H};
      4'h7:    return {1'b1, ardc_pkg::ADDR_FILT_REF, 8'h00};
      default: return {1'b0, ardc_pkg::ADDR_DIR_CFG, ardc_pkg::EX_DIR_CFG};
    endcase
  endfunction : cfg_op

  ardc_hstate_t state;
  logic [3:0]   idx;
  logic         mode_q;
  logic         eck_q;
  logic [16:0]  op;
  logic [3:0]   last_rd;
  logic [7:0]   evt_addr;

  assign op       = cfg_op(idx, mode_q, eck_q);
  assign last_rd  = mode_q ? 4'h6 : 4'h1;
  assign evt_addr = mode_q ? (ardc_pkg::ADDR_STATUS + ((idx == 4'h0) ? 8'h00 : {4'h0, idx}))
                           : (ardc_pkg::ADDR_DIR_SRC + {4'h0, idx});
  assign busy_o   = (state != ARDC_H_IDLE);

  // The strobe still out when polling resumes blocks a stale pin level.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state     <= ARDC_H_IDLE;
      idx       <= 4'h0;
      mode_q    <= 1'b0;
      eck_q     <= 1'b0;
      bus.wr    <= 1'b0;
      bus.rd    <= 1'b0;
      bus.addr  <= 8'h00;
      bus.wdata <= 8'h00;
    end else begin
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      case (state)
        ARDC_H_IDLE: begin
          idx    <= 4'h0;
          mode_q <= mode_data_i;
          eck_q  <= ext_clk_sel_i;
          if (start_i) begin
            state <= ARDC_H_CFG;
          end
        end
        ARDC_H_CFG: begin
          bus.rd    <= op[16];
          bus.wr    <= ~op[16];
          bus.addr  <= op[15:8];
          bus.wdata <= op[7:0];
          idx       <= idx + 4'h1;
          if (idx == 4'h8) begin
            state <= ARDC_H_POLL;
          end
        end
        ARDC_H_POLL: begin
          idx <= 4'h0;
          if (bus.rdy_int && !bus.rd) begin
            state <= ARDC_H_READ;
          end
        end
        ARDC_H_READ: begin
          bus.rd   <= 1'b1;
          bus.addr <= evt_addr;
          idx      <= idx + 4'h1;
          if (idx == last_rd) begin
            state <= ARDC_H_POLL;
          end
        end
        default: state <= ARDC_H_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Read capture and window check
  logic        pend;
  logic [7:0]  paddr;
  logic [19:0] win_cnt;
  logic        fin;

  assign fin = pend && (paddr == (mode_q ? ardc_pkg::ADDR_OUT_Z_H : ardc_pkg::ADDR_DIR_ACK));

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend      <= 1'b0;
      paddr     <= 8'h00;
      done_o    <= 1'b0;
      dir_src_o <= 8'h00;
      status_o  <= 8'h00;
      accel_x_o <= 16'h0000;
      accel_y_o <= 16'h0000;
      accel_z_o <= 16'h0000;
    end else begin
      // Every read is tracked: the last read of a service goes out as the state returns to POLL.
      pend   <= bus.rd;
      paddr  <= bus.addr;
      done_o <= fin;
      if (pend) begin
        case (paddr)
          ardc_pkg::ADDR_DIR_SRC: dir_src_o       <= bus.rdata;
          ardc_pkg::ADDR_STATUS:  status_o        <= bus.rdata;
          8'h28:                  accel_x_o[7:0]  <= bus.rdata;
          8'h29:                  accel_x_o[15:8] <= bus.rdata;
          8'h2A:                  accel_y_o[7:0]  <= bus.rdata;
          8'h2B:                  accel_y_o[15:8] <= bus.rdata;
          8'h2C:                  accel_z_o[7:0]  <= bus.rdata;
          ardc_pkg::ADDR_OUT_Z_H: accel_z_o[15:8] <= bus.rdata;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      win_cnt <= 20'h0_0000;
      late_o  <= 1'b0;
    end else begin
      if (state == ARDC_H_POLL && bus.rdy_int && !bus.rd) begin
        win_cnt <= 20'h0_0000;
      end else if (win_cnt != 20'hF_FFFF) begin
        win_cnt <= win_cnt + 20'h0_0001;
      end
      if (fin && (win_cnt > 20'(READ_WIN_P))) begin
        late_o <= 1'b1;
      end
    end
  end

endmodule : ardc_host

`default_nettype wire

// ---- ardc_chk_sva.sv ----
// Purpose: Link checks.
// Assumes: One clock.
// Notes:   Inputs are the link signals.
`timescale 1ns/1ps
`default_nettype none
module ardc_chk (
  // Link
  input wire logic       sys_clk_i,
  input wire logic       rst_n_i,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       rdy_int
);
  // ======
  // Checks
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_excl; !(wr && rd); endproperty
  a_excl: assert property (p_excl) else $error("excl");
  property p_idle; rdata != 8'h00 |-> $past(rd); endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_cfg;
    (wr && addr == 8'h22) |-> (wdata[6:0] == 7'h4B) ##1 (wr && addr == 8'h3E && wdata == 8'hA3)
      ##1 (wr && addr == 8'h3F && wdata == 8'h10) ##1 (wr && addr == 8'h3C && wdata == 8'h99)
      ##1 (wr && addr == 8'h3D && wdata == 8'h09) ##1 (rd && addr == 8'h23)
      ##1 (wr && addr == 8'h38 && wdata == 8'hCF);
  endproperty
  a_cfg: assert property (p_cfg) else $error("cfg");
  property p_ord; rd && addr == 8'h39 |=> rd && addr == 8'h3A; endproperty
  a_ord: assert property (p_ord) else $error("ord");
  property p_ack; rd && addr == 8'h3A |=> !rdy_int; endproperty
  a_ack: assert property (p_ack) else $error("ack");
  property p_stat; rd && addr == 8'h27 |=> rdata[3]; endproperty
  a_stat: assert property (p_stat) else $error("stat");
  property p_full; rd && addr == 8'h2D |=> !rdy_int; endproperty
  a_full: assert property (p_full) else $error("full");
  property p_pin; $rose(rdy_int) |-> ##[0:3] rd; endproperty
  a_pin: assert property (p_pin) else $error("pin");
  c_pin: cover property ($rose(rdy_int));
  c_ack: cover property (rd && addr == 8'h3A);
  c_full: cover property (rd && addr == 8'h2D);
endmodule : ardc_chk
`default_nettype wire

// ---- accel_rate_ready_direction_ctl_test.sv ----
// Purpose: Host and sensor back to back.
// Assumes: Sample divider cut to 4.
// Notes:   Direction mode, then data mode on the internal and then the external clock.
`timescale 1ns/1ps
`default_nettype none
module accel_rate_ready_direction_ctl_test;
  logic        clk, rst_n, go, mode, done, late, ext, external_clock_select, busy;
  logic [7:0]  src, stat;
  logic [15:0] ax, ox, ay, oy;
  int          n_fail, total_checks, cyc, t0;
  logic [15:0] tilt [3] = '{16'h2000, 16'hE000, 16'h0000};
  logic [7:0]  want [3] = '{8'h42, 8'h41, 8'h40};
  ardc_if bus_if ();
  ardc_device #(.MOD_DIV_P(4), .EXT_DIV_P(2)) ardc_device_inst (.sys_clk_i(clk),
    .rst_n_i(rst_n), .bus(bus_if.dev), .ext_clk_i(ext), .accel_x_i(ax),
    .accel_y_i(ay), .accel_z_i(16'h0000));
  ardc_host #(.READ_WIN_P(200)) ardc_host_inst (.sys_clk_i(clk), .rst_n_i(rst_n),
    .bus(bus_if.hst), .start_i(go), .mode_data_i(mode), .ext_clk_sel_i(external_clock_select), .busy_o(busy),
    .done_o(done), .late_o(late), .dir_src_o(src), .status_o(stat), .accel_x_o(ox),
    .accel_y_o(oy), .accel_z_o());
  ardc_chk ardc_chk_inst (.sys_clk_i(clk), .rst_n_i(rst_n), .addr(bus_if.addr),
    .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata),
    .rdy_int(bus_if.rdy_int));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // External clock of eight system cycles, its edges on falling system edges, half a cycle from the rising ones.
  initial begin
    ext = 1'b0;
    forever #80 ext = ~ext;
  end
  // A hang past every expected wait ends the run as a failure.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_done();
    int i;
    i = 0;
    do begin
      @(posedge clk);
      #1;
      i++;
    end while (done !== 1'b1 && i < 9000);
    if (i == 9000) n_fail++;
  endtask : wait_done
  task automatic boot(input logic m);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    check(bus_if.rdy_int, 1'b0);
    check(busy, 1'b0);
    @(posedge clk);
    go <= 1'b1;
    mode <= m;
    @(posedge clk);
    go <= 1'b0;
  endtask : boot
  task automatic stop_test();
    if (n_fail == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  initial begin
    rst_n = 1'b0;
    go = 1'b0;
    mode = 1'b0;
    ax = 16'h0000;
    ay = 16'h0000;
    external_clock_select = 1'b0;
    boot(1'b0);
    repeat (6144) @(posedge clk);
    #1;
    check(src, 8'h00);
    foreach (tilt[k]) begin
      @(posedge clk);
      ax <= tilt[k];
      wait_done();
      check(src, want[k]);
      check(bus_if.rdy_int, 1'b0);
    end
    boot(1'b1);
    ax <= 16'h0123;
    ay <= 16'h0456;
    wait_done();
    t0 = cyc;
    check(ox, 16'h0123);
    check(oy, 16'h0456);
    check(busy, 1'b1);
    check(stat, 8'h08);
    check(late, 1'b0);
    wait_done();
    check(16'(cyc - t0), 16'h0800);
    external_clock_select <= 1'b1;
    boot(1'b1);
    wait_done();
    t0 = cyc;
    wait_done();
    check(16'(cyc - t0), 16'h2000);
    stop_test();
  end
endmodule : accel_rate_ready_direction_ctl_test
`default_nettype wire
